// ---- include/tdm_pkg.sv ----
// Constants, register map and carrier types of the thermal domain monitor.
// Assumes a 32-bit AHB-Lite slave window with byte addresses below 0x100.
package tdm_pkg;

  // ****************
  // Sizes
  // ****************
  localparam int NCH     = 3;           // Selectable host/domain channels
  localparam int NFLD    = 4;           // Host/domain interrupt fields
  localparam int TW      = 16;          // Temperature width
  localparam int IRQW    = 11;          // 3 events plus 4 two-bit fields
  localparam int RTW     = 4;           // Retry count width

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_POLL   = 8'h00; // Poll interval, 4096-cycle ticks
  localparam logic [7:0] OFS_RETRY  = 8'h04; // Attempts before an error
  localparam logic [7:0] OFS_OFFSET = 8'h08; // Relative-to-absolute offset
  localparam logic [7:0] OFS_DOMEN  = 8'h0C; // Channel enables
  localparam logic [7:0] OFS_THR0   = 8'h10; // Thresholds, one word each
  localparam logic [7:0] OFS_VAL0   = 8'h20; // Current values, write clears
  localparam logic [7:0] OFS_MAX0   = 8'h30; // Max/error values, write clears
  localparam logic [7:0] OFS_RIS    = 8'h40; // Raw interrupt status
  localparam logic [7:0] OFS_MIS    = 8'h44; // Masked interrupt status
  localparam logic [7:0] OFS_IEN    = 8'h48; // Interrupt enables
  localparam logic [7:0] OFS_IMODE  = 8'h4C; // Two mode bits per field
  localparam logic [7:0] OFS_ICR    = 8'h50; // Write one to clear
  localparam logic [7:0] CH_STRIDE  = 8'h04; // Step between channel words

  // ****************
  // Field positions
  // ****************
  localparam int IRQ_READ = 0;          // Read done event
  localparam int IRQ_ERR  = 1;          // Transaction error event
  localparam int IRQ_ADV  = 2;          // Advanced command done event
  localparam int IRQ_FLD0 = 3;          // First host/domain field
  localparam int THR_HI   = 16;         // High threshold lsb in its word
  localparam int MAX_ERR  = 31;         // Error flag in the max word
  // Channel to field: ch0 -> host0_dom0, ch1 -> host1_dom0, ch2 -> host1_dom1
  localparam logic [5:0] CH_FLD_MAP = 6'h38;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [TW-1:0]  RST_POLL   = 16'h0000; // Polling off
  localparam logic [RTW-1:0] RST_RETRY  = 4'h1;
  localparam logic [TW-1:0]  RST_OFFSET = 16'h0000; // Relative mode
  localparam logic [31:0]    RST_THR    = 32'h0000_0000;
  localparam int             PRESCALE   = 4096;     // Poll pre-divider
  localparam int             PRE_W      = 12;

  // ****************************************************************
  // Zone codes and interrupt modes
  // ****************************************************************
  localparam logic [1:0] ZN_LOW   = 2'h1;
  localparam logic [1:0] ZN_MID   = 2'h2;
  localparam logic [1:0] ZN_HIGH  = 2'h3;
  localparam logic [1:0] MODE_HI  = 2'h1; // single_zone_high only
  localparam logic [1:0] MODE_MH  = 2'h2; // two_zone_mid / two_zone_high
  localparam logic [1:0] MODE_ALL = 2'h3; // three_zone_low/mid/high

  typedef enum logic {ST_IDLE = 1'b0, ST_WAIT = 1'b1} tdm_state_e;

  // Result of one link transaction, from the wire engine
  typedef struct packed {
    logic          valid;  // One-cycle result strobe
    logic          ok;     // Transaction succeeded
    logic [TW-1:0] temp;   // Relative temperature, signed
  } tdm_meas_s;

  // Transaction request toward the wire engine
  typedef struct packed {
    logic       req;       // One-cycle start pulse
    logic [1:0] chan;      // Channel index 0..2
  } tdm_req_s;

endpackage : tdm_pkg

// ---- hdl/tdm_top.sv ----
// Thermal domain monitor: thresholds, values, polling and interrupts.
// Assumes one clock and an engine answering each request once.
//
// Behaviour
// [R01] Per-domain high and low thresholds, written independently; here both halves take one whole-word write
// [R02] Compare relative, or absolute with nonzero offset
// [R03] Three channels, own configuration and enable
// [R04] Enabled domains polled, disabled ones skipped
// [R05] Disabling one domain leaves others untouched
// [R06] Max value holds highest reading, flags errors
// [R07] Clearing max restarts tracking next measurement
// [R08] Current value updated each successful transaction
// [R09] Clearing current value independent of max
// [R10] Seven interrupt sources, clear deasserts them
// [R11] Software clears sources early in handler
// [R12] Only enabled sources reach interrupt output
// [R13] Raw and masked status both readable
// [R14] Programmable interrupt mode per domain field
// [R15] Field encodes zone according to mode
// [R16] High above, low below, mid between
// [R17] Status cleared by writing one; zero ignored
// [R18] Poll counter on clock divided by 4096
// [R19] Retry up to programmed count, then error
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/10ps
module tdm_top (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire tdm_pkg::tdm_meas_s meas,
  input  wire logic              adv_done,
  output tdm_pkg::tdm_req_s      xfer,
  output logic                   irq
);
  import tdm_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic            wr_ph_r;            // Write data phase
  logic            rd_ph_r;            // Read wait cycle
  logic [7:0]      addr_r;             // Captured low address
  logic            map_r;              // Address inside the window
  logic [31:0]     hrdata_r;           // Registered read data
  logic [31:0]     rd_mux;             // Read selection
  logic            acc;                // Address phase taken
  logic            wr;                 // Register write strobe
  logic [TW-1:0]   poll_r;             // Poll interval
  logic [RTW-1:0]  retry_r;            // Attempts allowed
  logic [TW-1:0]   offset_r;           // Conversion offset
  logic [NCH-1:0]  dom_en_r;           // Channel enables
  logic [31:0]     thr_r [NCH];        // {high, low} per channel
  logic [TW-1:0]   val_r [NCH];        // Current value
  logic [TW-1:0]   max_r [NCH];        // Highest value since clear
  logic [NCH-1:0]  max_vld_r;          // Max holds a reading
  logic [NCH-1:0]  max_err_r;          // Error seen since clear
  logic [IRQW-1:0] ris_r, ris_nxt;     // Raw status
  logic [IRQW-1:0] ien_r;              // Interrupt enables
  logic [2*NFLD-1:0] imode_r;          // Modes, two bits per field
  logic [PRE_W-1:0] pre_r;             // Pre-divider
  logic [TW-1:0]   pcnt_r;             // Poll tick counter
  logic            tick, poll_fire;
  logic [NCH-1:0]  pend_r;             // Channels owed a transaction
  logic [NCH-1:0]  avail, take;
  logic [1:0]      pick;
  logic            pick_vld;
  tdm_state_e      st_r;
  logic [1:0]      cur_r;              // Channel in flight
  logic [RTW-1:0]  try_r;              // Failed attempts so far
  logic            req_r;
  logic            done_ok, fail, err_ev;
  logic [TW-1:0]   conv;               // Converted reading
  logic [NCH-1:0]  upd, rep;           // Per channel update/report
  logic [1:0]      zone [NCH];

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Reads take one wait state so that hrdata comes from a flop
  assign acc       = hsel && htrans[1] && hready;
  assign hreadyout = !rd_ph_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign wr        = wr_ph_r && map_r;

  // Phase tracking and read capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_ph_r  <= 1'b0;
      rd_ph_r  <= 1'b0;
      addr_r   <= 8'h00;
      map_r    <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_ph_r <= acc && hwrite;
      rd_ph_r <= acc && !hwrite;
      if (acc) begin
        addr_r <= haddr[7:0];
        map_r  <= (haddr[31:8] == 24'h00_0000);
      end
      if (rd_ph_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Read selection; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (map_r) begin
      case (addr_r)
        OFS_POLL:   rd_mux = {16'h0000, poll_r};
        OFS_RETRY:  rd_mux = {28'h000_0000, retry_r};
        OFS_OFFSET: rd_mux = {16'h0000, offset_r};
        OFS_DOMEN:  rd_mux = {29'h0000_0000, dom_en_r};
        OFS_RIS:    rd_mux = {21'h00_0000, ris_r};             // [R13]
        OFS_MIS:    rd_mux = {21'h00_0000, ris_r & ien_r};     // [R13]
        OFS_IEN:    rd_mux = {21'h00_0000, ien_r};
        OFS_IMODE:  rd_mux = {24'h00_0000, imode_r};
        default:    rd_mux = 32'h0000_0000;
      endcase
      for (int c = 0; c < NCH; c++) begin
        if (addr_r == OFS_THR0 + 8'(c) * CH_STRIDE) begin
          rd_mux = thr_r[c];
        end
        if (addr_r == OFS_VAL0 + 8'(c) * CH_STRIDE) begin
          rd_mux = {16'h0000, val_r[c]};
        end
        if (addr_r == OFS_MAX0 + 8'(c) * CH_STRIDE) begin
          rd_mux = {max_err_r[c], 15'h0000, max_r[c]};          // [R06]
        end
      end
    end
  end

  // ****************************************************************
  // Global configuration
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      poll_r   <= RST_POLL;
      retry_r  <= RST_RETRY;
      offset_r <= RST_OFFSET;
      dom_en_r <= '0;
      ien_r    <= '0;
      imode_r  <= '0;
    end else if (wr) begin
      case (addr_r)
        OFS_POLL:   poll_r   <= hwdata[TW-1:0];
        OFS_RETRY:  retry_r  <= hwdata[RTW-1:0];
        OFS_OFFSET: offset_r <= hwdata[TW-1:0];
        // Whole-word write: each bit governs only its channel
        OFS_DOMEN:  dom_en_r <= hwdata[NCH-1:0];               // [R05]
        OFS_IEN:    ien_r    <= hwdata[IRQW-1:0];              // [R12]
        OFS_IMODE:  imode_r  <= hwdata[2*NFLD-1:0];            // [R14]
        default:    ;
      endcase
    end
  end

  // ****************************************************************
  // Poll timing
  // ****************************************************************
  assign tick      = (pre_r == PRE_W'(PRESCALE - 1));          // [R18]
  assign poll_fire = tick && (poll_r != '0) &&
                     (pcnt_r >= poll_r - 16'h0001);            // [R18]

  // Free-running pre-divider; interval counter held at zero while polling is off
  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_r  <= '0;
      pcnt_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
      if (poll_r == '0) begin
        pcnt_r <= '0;                                          // [R18]
      end else if (poll_fire) begin
        pcnt_r <= '0;
      end else if (tick) begin
        pcnt_r <= pcnt_r + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Channel scheduling and transaction sequencer
  // ****************************************************************
  assign avail = pend_r & dom_en_r;                            // [R04]

  // Lowest pending enabled channel goes first
  always_comb begin
    pick     = 2'h0;
    pick_vld = 1'b0;
    take     = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (avail[c]) begin
        pick     = 2'(c);
        pick_vld = 1'b1;
      end
    end
    if (st_r == ST_IDLE && pick_vld) begin
      take[pick] = 1'b1;
    end
  end

  // Disabled channels drop out of the round at once
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_r <= '0;
    end else begin
      pend_r <= ((poll_fire ? dom_en_r : pend_r) & dom_en_r) & ~take;
    end
  end

  assign done_ok = (st_r == ST_WAIT) && meas.valid && meas.ok;
  assign fail    = (st_r == ST_WAIT) && meas.valid && !meas.ok;
  // Retry count of zero still means one attempt
  assign err_ev  = fail && (RTW'(try_r + 1'b1) >= retry_r);   // [R19]
  assign xfer    = '{req: req_r, chan: cur_r};

  // One transaction outstanding at a time
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r  <= ST_IDLE;
      cur_r <= 2'h0;
      try_r <= '0;
      req_r <= 1'b0;
    end else begin
      req_r <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (pick_vld) begin
            cur_r <= pick;
            try_r <= '0;
            req_r <= 1'b1;
            st_r  <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (done_ok || err_ev) begin
            st_r <= ST_IDLE;
          end else if (fail) begin
            try_r <= try_r + 1'b1;                              // [R19]
            req_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Per-channel storage
  // ****************************************************************
  // Zero offset leaves readings relative to the maximum
  assign conv = TW'(meas.temp + offset_r);                     // [R02]

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam int F = int'(CH_FLD_MAP[2*c +: 2]);
    localparam logic [7:0] OT = OFS_THR0 + 8'(c) * CH_STRIDE;
    localparam logic [7:0] OV = OFS_VAL0 + 8'(c) * CH_STRIDE;
    localparam logic [7:0] OM = OFS_MAX0 + 8'(c) * CH_STRIDE;
    logic [1:0] mode;

    // Results of a channel disabled mid-flight are dropped
    assign upd[c] = done_ok && (cur_r == 2'(c)) && dom_en_r[c];

    // Zone by signed compare against thresholds
    always_comb begin
      if ($signed(conv) > $signed(thr_r[c][31:THR_HI])) begin
        zone[c] = ZN_HIGH;                                     // [R16]
      end else if ($signed(conv) < $signed(thr_r[c][THR_HI-1:0])) begin
        zone[c] = ZN_LOW;                                      // [R16]
      end else begin
        zone[c] = ZN_MID;                                      // [R16]
      end
    end

    assign mode   = imode_r[2*F +: 2];                         // [R14]
    assign rep[c] = (mode == MODE_ALL) ||
                    (mode == MODE_MH && zone[c] != ZN_LOW) ||
                    (mode == MODE_HI && zone[c] == ZN_HIGH);   // [R15]

    // High and low halves written together by one whole-word write
    always_ff @(posedge mclk) begin
      if (reset) begin
        thr_r[c] <= RST_THR;
      end else if (wr && addr_r == OT) begin
        thr_r[c] <= hwdata;                                    // [R01]
      end
    end

    // Current value; a fresh reading beats a same-cycle clear
    always_ff @(posedge mclk) begin
      if (reset) begin
        val_r[c] <= '0;
      end else if (upd[c]) begin
        val_r[c] <= conv;                                      // [R08]
      end else if (wr && addr_r == OV) begin
        val_r[c] <= '0;                                        // [R09]
      end
    end

    // Max/error tracking
    always_ff @(posedge mclk) begin
      if (reset) begin
        max_r[c]     <= '0;
        max_vld_r[c] <= 1'b0;
        max_err_r[c] <= 1'b0;
      end else if (wr && addr_r == OM) begin
        max_r[c]     <= '0;                                    // [R07]
        max_vld_r[c] <= 1'b0;
        max_err_r[c] <= 1'b0;
      end else if (upd[c]) begin
        if (!max_vld_r[c] || $signed(conv) > $signed(max_r[c])) begin
          max_r[c] <= conv;                                    // [R06]
        end
        max_vld_r[c] <= 1'b1;
      end else if (err_ev && cur_r == 2'(c)) begin
        max_err_r[c] <= 1'b1;                                  // [R06]
      end
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Clear first, then sets, so a new event is never lost
  always_comb begin
    ris_nxt = ris_r;
    if (wr && addr_r == OFS_ICR) begin
      ris_nxt = ris_r & ~hwdata[IRQW-1:0];                     // [R17]
    end
    if (done_ok) begin
      ris_nxt[IRQ_READ] = 1'b1;                                // [R10]
    end
    if (err_ev) begin
      ris_nxt[IRQ_ERR] = 1'b1;                                 // [R10]
    end
    if (adv_done) begin
      ris_nxt[IRQ_ADV] = 1'b1;                                 // [R10]
    end
    for (int c = 0; c < NCH; c++) begin
      if (upd[c] && rep[c]) begin
        ris_nxt[IRQ_FLD0 + 2*int'(CH_FLD_MAP[2*c +: 2]) +: 2] = zone[c];
      end
    end
  end

  // Raw status register
  always_ff @(posedge mclk) begin
    if (reset) begin
      ris_r <= '0;
    end else begin
      ris_r <= ris_nxt;                                        // [R15]
    end
  end

  // Level output from flops; handler should clear early
  assign irq = |(ris_r & ien_r);                               // [R12] [R11]

endmodule : tdm_top

// ---- dv/tdm_top_asserts.sv ----
// Port-level checker for the thermal domain monitor top.
// Assumes one clock domain, sync active-high reset, hready tied to hreadyout.
`timescale 1ns/10ps
module tdm_top_asserts (
  input wire logic               mclk,
  input wire logic               reset,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire tdm_pkg::tdm_meas_s meas,
  input wire logic               adv_done,
  input wire tdm_pkg::tdm_req_s  xfer,
  input wire logic               irq
);
  import tdm_pkg::*;

  // ****************
  // Helper state
  // ****************
  logic wr_dp_r;  // Write data phase in progress
  logic pend_r;   // Link request outstanding

  // Marks the data phase of an accepted write
  always_ff @(posedge mclk) begin
    if (reset) wr_dp_r <= 1'b0;
    else       wr_dp_r <= hsel & htrans[1] & hready & hwrite;
  end

  // Tracks the single outstanding link request
  always_ff @(posedge mclk) begin
    if (reset)           pend_r <= 1'b0;
    else if (xfer.req)   pend_r <= 1'b1;
    else if (meas.valid) pend_r <= 1'b0;
  end

  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wr;
    hsel && htrans[1] && hready && hwrite;
  endsequence

  property p_rd_wait;   s_rd |=> !hreadyout ##1 hreadyout; endproperty
  property p_wr_nowait; s_wr |=> hreadyout; endproperty
  property p_unmapped;
    s_rd ##0 (haddr[31:8] != 24'h0) |=> ##1 (hrdata == 32'h0);
  endproperty
  property p_okay;      hresp == 1'b0; endproperty
  property p_irq_rise;
    $rose(irq) |-> $past(meas.valid) || $past(adv_done) || $past(wr_dp_r);
  endproperty
  property p_irq_fall;  $fell(irq) |-> $past(wr_dp_r); endproperty
  property p_one_out;   xfer.req |-> !pend_r ##1 !xfer.req; endproperty
  property p_chan_hold; $changed(xfer.chan) |-> xfer.req; endproperty
  property p_chan_rng;  xfer.req |-> xfer.chan != 2'h3; endproperty

  a_rd_wait: assert property (p_rd_wait)
    else $error("read wait cycle wrong");
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write stalled");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_okay: assert property (p_okay)
    else $error("response not okay");
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq rose without cause");
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without write");
  a_one_out: assert property (p_one_out)
    else $error("second request outstanding");
  a_chan_hold: assert property (p_chan_hold)
    else $error("channel moved without request");
  a_chan_rng: assert property (p_chan_rng)
    else $error("channel index out of range");

endmodule : tdm_top_asserts

bind tdm_top tdm_top_asserts u_chk (
  .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .meas(meas),
  .adv_done(adv_done), .xfer(xfer), .irq(irq)
);

// ---- dv/tdm_engine_model.sv ----
// Behavioural wire engine standing beyond the link port.
// Assumes requests arrive as one-cycle pulses, one outstanding at a time.
`timescale 1ns/10ps
module tdm_engine_model (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire tdm_pkg::tdm_req_s xfer,
  input  wire logic              ok_i,
  input  wire logic [7:0]        lat_i,
  input  wire logic [2:0][15:0]  temp_i,
  output tdm_pkg::tdm_meas_s     meas,
  output int                     n_req
);
  import tdm_pkg::*;

  // ****************
  // Answer engine
  // ****************
  logic [7:0] cnt_r;   // Cycles left before the answer
  logic       busy_r;  // Request in flight
  logic [1:0] ch_r;    // Channel being read

  // Answers lat_i + 2 cycles after each request
  always_ff @(posedge mclk) begin
    meas.valid <= !reset && !xfer.req && busy_r && (cnt_r == 8'h00);
    if (reset) begin
      busy_r <= 1'b0;
      n_req  <= 0;
      cnt_r  <= 8'h00;
    end else if (xfer.req) begin
      busy_r <= 1'b1;
      cnt_r  <= lat_i;
      ch_r   <= xfer.chan;
      n_req  <= n_req + 1;
    end else if (busy_r && cnt_r == 8'h00) begin
      meas.ok   <= ok_i;
      meas.temp <= temp_i[ch_r];
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end

endmodule : tdm_engine_model

// ---- dv/testbench.sv ----
// Self-checking bench: AHB-Lite register tasks and polling rounds.
// Assumes the engine model answers every request of the monitor.
`timescale 1ns/10ps
module testbench;
  import tdm_pkg::*;

  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic              hsel = 1'b0;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       hwdata = 32'h0;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  tdm_meas_s         meas;
  logic              adv_done = 1'b0;
  tdm_req_s          xfer;
  logic              irq;
  logic              ok_i = 1'b1;
  logic [7:0]        lat_i = 8'h03;
  logic [2:0][15:0]  temp_i = '0;
  logic [23:0]       page = 24'h0;  // Upper address bits, nonzero = unmapped
  int                n_req;
  int                fails = 0;
  int                comparisons = 0;
  logic [31:0]       v;

  always #12.5 mclk = ~mclk;  // 40 MHz

  tdm_top DUT (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .meas(meas), .adv_done(adv_done), .xfer(xfer),
    .irq(irq));
  tdm_engine_model u_eng (.mclk(mclk), .reset(reset), .xfer(xfer),
    .ok_i(ok_i), .lat_i(lat_i), .temp_i(temp_i), .meas(meas),
    .n_req(n_req));

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Ready sampled mid-cycle, away from the edge
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge mclk);
      r = hreadyout;
      d = hrdata;
      @(posedge mclk);
    end while (r !== 1'b1);
  endtask : wait_rdy

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    haddr <= {page, a};
    hwrite <= 1'b1;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_rdy(x);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(x);
  endtask : bus_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    haddr <= {page, a};
    hwrite <= 1'b0;
    htrans <= 2'b10;
    hsel <= 1'b1;
    wait_rdy(v);
    htrans <= 2'b00;
    wait_rdy(v);
    chk(v, e);
  endtask : rd_chk

  // Counts result strobes; a missing one counts as a mismatch
  task automatic wait_meas(input int n);
    int t;
    t = 0;
    while (n > 0 && t < 20000) begin
      @(negedge mclk);
      t++;
      if (meas.valid === 1'b1) n--;
    end
    if (n > 0) fails++;
    repeat (3) @(posedge mclk);
  endtask : wait_meas

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd_chk(OFS_POLL, 32'h0);
    rd_chk(OFS_RETRY, 32'h1);
    rd_chk(OFS_DOMEN, 32'h0);
    page = 24'h000001;
    bus_wr(OFS_POLL, 32'hFFFF);
    rd_chk(OFS_RETRY, 32'h0);
    rd_chk(OFS_POLL, 32'h0);
    page = 24'h0;
    rd_chk(OFS_POLL, 32'h0);
    // Round 1: ch0 mid, ch2 high, all fields in three-zone mode
    bus_wr(OFS_THR0, 32'h0030_0010);
    bus_wr(OFS_THR0 + 8'h08, 32'h0050_0040);
    rd_chk(OFS_THR0, 32'h0030_0010);
    rd_chk(OFS_THR0 + 8'h08, 32'h0050_0040);
    temp_i = {16'h0060, 16'h0000, 16'h0020};
    bus_wr(OFS_IEN, 32'h7FF);
    bus_wr(OFS_IMODE, 32'hFF);
    bus_wr(OFS_DOMEN, 32'h5);
    bus_wr(OFS_POLL, 32'h1);
    wait_meas(2);
    bus_wr(OFS_POLL, 32'h0);
    chk(32'(n_req), 32'd2);
    rd_chk(OFS_VAL0, 32'h0020);
    rd_chk(OFS_VAL0 + 8'h04, 32'h0);
    rd_chk(OFS_VAL0 + 8'h08, 32'h0060);
    rd_chk(OFS_MAX0, 32'h0020);
    rd_chk(OFS_RIS, 32'h611);
    rd_chk(OFS_MIS, 32'h611);
    chk(32'(irq), 32'h1);
    bus_wr(OFS_IEN, 32'h0);
    rd_chk(OFS_MIS, 32'h0);
    chk(32'(irq), 32'h0);
    bus_wr(OFS_IEN, 32'h7FF);
    bus_wr(OFS_ICR, 32'h0);
    rd_chk(OFS_RIS, 32'h611);
    bus_wr(OFS_ICR, 32'h011);
    rd_chk(OFS_RIS, 32'h600);
    bus_wr(OFS_ICR, 32'h7FF);
    @(negedge mclk);
    chk(32'(irq), 32'h0);
    // Round 2: lower readings, zones the modes do not report
    temp_i = {16'h0040, 16'h0000, 16'h0008};
    bus_wr(OFS_IMODE, 32'h42);
    bus_wr(OFS_POLL, 32'h1);
    wait_meas(2);
    bus_wr(OFS_POLL, 32'h0);
    rd_chk(OFS_VAL0, 32'h0008);
    rd_chk(OFS_MAX0, 32'h0020);
    rd_chk(OFS_MAX0 + 8'h08, 32'h0060);
    rd_chk(OFS_RIS, 32'h001);
    bus_wr(OFS_MAX0, 32'h0);
    rd_chk(OFS_MAX0, 32'h0);
    bus_wr(OFS_VAL0 + 8'h08, 32'h0);
    rd_chk(OFS_VAL0 + 8'h08, 32'h0);
    rd_chk(OFS_MAX0 + 8'h08, 32'h0060);
    // Round 3: offset gives absolute values, ch2 disabled
    bus_wr(OFS_ICR, 32'h7FF);
    temp_i = {16'h0040, 16'h0000, 16'h0040};
    bus_wr(OFS_OFFSET, 32'h0100);
    bus_wr(OFS_IMODE, 32'h11);
    bus_wr(OFS_DOMEN, 32'h3);
    bus_wr(OFS_POLL, 32'h1);
    wait_meas(2);
    bus_wr(OFS_POLL, 32'h0);
    rd_chk(OFS_VAL0, 32'h0140);
    rd_chk(OFS_MAX0, 32'h0140);
    rd_chk(OFS_RIS, 32'h199);
    rd_chk(OFS_VAL0 + 8'h08, 32'h0);
    rd_chk(OFS_THR0 + 8'h08, 32'h0050_0040);
    chk(32'(n_req), 32'd6);
    // Round 4: slow failing engine, two attempts then error
    bus_wr(OFS_ICR, 32'h7FF);
    ok_i <= 1'b0;
    lat_i <= 8'd20;
    bus_wr(OFS_RETRY, 32'h2);
    bus_wr(OFS_DOMEN, 32'h1);
    bus_wr(OFS_POLL, 32'h1);
    wait_meas(2);
    bus_wr(OFS_POLL, 32'h0);
    chk(32'(n_req), 32'd8);
    rd_chk(OFS_RIS, 32'h002);
    rd_chk(OFS_MAX0, 32'h8000_0140);
    adv_done <= 1'b1;
    @(posedge mclk);
    adv_done <= 1'b0;
    @(posedge mclk);
    rd_chk(OFS_RIS, 32'h006);
    repeat (9000) @(posedge mclk);
    chk(32'(n_req), 32'd8);
    summarize();
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    summarize();
  end

endmodule : testbench
